// ---- shared/pliu_pkg.sv ----
// Purpose: Shared constants for the local interrupt and user I/O block.
// Assumes: 32-bit register words, byte enables active high.
// Notes:   Offsets are byte addresses inside each register space.
package pliu_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CMD_STAT     = 8'h04;  // Config space, command and status
  localparam logic [7:0]  OFF_INT_LINE_PIN = 8'h3C;  // Config space, interrupt line and pin
  localparam logic [7:0]  OFF_IRQ_CSR      = 8'h4C;  // Local space, interrupt control/status
  localparam logic [7:0]  OFF_MISC_CTRL    = 8'h50;  // Local space, user I/O control

  // ----------------------------------------------------------------
  // Interrupt control/status field positions
  // ----------------------------------------------------------------
  localparam int unsigned CSR_L1_EN   = 0;  // Local input 1 enable
  localparam int unsigned CSR_L1_POL  = 1;  // Local input 1 polarity, 1 = active high
  localparam int unsigned CSR_L1_STAT = 2;  // Local input 1 active
  localparam int unsigned CSR_L2_EN   = 3;  // Local input 2 enable
  localparam int unsigned CSR_L2_POL  = 4;  // Local input 2 polarity, 1 = active high
  localparam int unsigned CSR_L2_STAT = 5;  // Local input 2 active
  localparam int unsigned CSR_PCI_EN  = 6;  // Global enable of local sources
  localparam int unsigned CSR_SW_IRQ  = 7;  // Software interrupt, also its enable

  // ----------------------------------------------------------------
  // Command and status field positions
  // ----------------------------------------------------------------
  localparam int unsigned CMD_MEM      = 0;   // Memory space enable
  localparam int unsigned CMD_IO       = 1;   // I/O space enable
  localparam int unsigned CMD_PAR_RESP = 6;   // Parity error response
  localparam int unsigned CMD_SERR_EN  = 8;   // System error output enable
  localparam int unsigned STAT_SIG_SERR = 30; // System error signalled, write one to clear
  localparam int unsigned STAT_DET_PAR  = 31; // Parity error detected, write one to clear

  // ----------------------------------------------------------------
  // User I/O control layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned USER_PINS  = 4;   // Multiplexed pins
  localparam int unsigned USER_FLD_W = 3;   // Bits per pin
  localparam int unsigned USER_ALT   = 0;   // 1 = alternate function
  localparam int unsigned USER_DIR   = 1;   // 1 = output
  localparam int unsigned USER_DAT   = 2;   // Output value, or pin level when input
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [7:0]  CSR_RESET  = 8'h00;
  localparam logic [7:0]  INT_PIN_VAL = 8'h01;  // Interrupt pin A
  localparam logic [7:0]  INT_LINE_RESET = 8'h00;

endpackage : pliu_pkg

// ---- shared/pliu_irq_if.sv ----
// Purpose: Carries interrupt controls and status between register file and core.
// Assumes: Single clock domain.
// Notes:   Index 0 is local input 1, index 1 is local input 2.
`timescale 1ns/1ps
`default_nettype none
interface pliu_irq_if;
  logic [1:0] lint_en;     // Per-input enable
  logic [1:0] lint_pol;    // Per-input polarity
  logic       pci_irq_en;  // Global enable for local inputs
  logic       sw_irq;      // Software interrupt
  logic [1:0] lint_stat;   // Per-input active
  logic       inta_active; // Registered interrupt level

  // Register side drives controls
  modport ctrl (output lint_en, output lint_pol, output pci_irq_en, output sw_irq,
                input lint_stat, input inta_active);
  // Core side computes status and level
  modport core (input lint_en, input lint_pol, input pci_irq_en, input sw_irq,
                output lint_stat, output inta_active);
endinterface : pliu_irq_if
`default_nettype wire

// ---- verilog/pliu_irq_core.sv ----
// Purpose: Synchronises local interrupt inputs and forms the interrupt level.
// Assumes: Local inputs are asynchronous levels.
// Notes:   Status follows the pin regardless of enables.
`timescale 1ns/1ps
`default_nettype none
module pliu_irq_core (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Local interrupt pins
  input  wire logic [1:0] i_local_irq_in,
  // Controls and status
  pliu_irq_if.core        bus
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync_a;  // First stage, read only by second
  logic [1:0] sync_b;  // Second stage, safe to use
  logic       next_inta;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_src
      // Two flops per pin against metastability
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= i_local_irq_in[g];
          sync_b[g] <= sync_a[g];
        end
      end
      // Level sensitive, polarity from the register
      assign bus.lint_stat[g] = ~(sync_b[g] ^ bus.lint_pol[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt level
  // ----------------------------------------------------------------
  // Enabled active sources OR together; software bit is its own enable
  always_comb begin
    next_inta = (bus.pci_irq_en & |(bus.lint_stat & bus.lint_en)) | bus.sw_irq;
  end

  // Registered so the pin never glitches while sources change
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus.inta_active <= 1'b0;
    end else begin
      bus.inta_active <= next_inta;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_inta_hold;
    @(posedge i_mclk) disable iff (i_rst)
      (bus.pci_irq_en && bus.lint_en[1] && bus.lint_stat[1]) |=> bus.inta_active;
  endproperty
  a_inta_hold: assert property (p_inta_hold) else $error("interrupt dropped while source active");

  property p_inta_clear;
    @(posedge i_mclk) disable iff (i_rst)
      (!bus.sw_irq && !(bus.pci_irq_en && |(bus.lint_en & bus.lint_stat))) |=> !bus.inta_active;
  endproperty
  a_inta_clear: assert property (p_inta_clear) else $error("interrupt held with no enabled cause");

  property p_sw_irq;
    @(posedge i_mclk) disable iff (i_rst)
      bus.sw_irq [*2] |-> bus.inta_active;
  endproperty
  a_sw_irq: assert property (p_sw_irq) else $error("software interrupt not asserted");

  property p_pol;
    @(posedge i_mclk) disable iff (i_rst)
      ($stable(bus.lint_pol) && !$past(i_rst, 2)) |->
        bus.lint_stat[1] == ($past(i_local_irq_in[1], 2) == bus.lint_pol[1]);
  endproperty
  a_pol: assert property (p_pol) else $error("input 2 status ignores polarity");

endmodule : pliu_irq_core
`default_nettype wire

// ---- verilog/pliu_top.sv ----
// Purpose: Interrupt, system error and user I/O pin logic of a bus target bridge.
// Assumes: One clock, synchronous active-high reset, same-clock register strobes.
// Notes:   Read data appears one cycle after the read strobe, with o_cfg_ack.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Either local input can raise INTA
// - Per-input enable masks its contribution
// - Readable active status for each source
// - Software interrupt bit 7 raises INTA
// - INTA is a level while source active
// - Clearing enable or cause drops INTA
// - Level inputs, polarity bits 4 and 1
// - SERR pulse on parity error, bit 6
// - SERR only with command bit 8 set
// - User pins share wait, lock, selects
// - Control register picks function and direction
// - Reset selects user function on pins
// - Reset makes all user pins inputs
module pliu_top (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // Register access
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic        i_cfg_space,   // 0 config space, 1 local space
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_ack,
  // Interrupt pins
  input  wire logic [1:0]  i_local_irq_in,
  output logic             o_inta_n_out,
  output logic             o_inta_oe_n,
  // Parity errors and system error pin
  input  wire logic        i_addr_par_err,
  input  wire logic        i_data_par_err,
  output logic             o_serr_n_out,
  output logic             o_serr_oe_n,
  // Alternate pin functions
  input  wire logic        i_wait_out_n,
  input  wire logic        i_lock_out_n,
  input  wire logic        i_chip_select_two_n,
  input  wire logic        i_chip_select_three_n,
  // User pins
  input  wire logic [3:0]  i_user_in,
  output logic      [3:0]  o_user_out,
  output logic      [3:0]  o_user_oe_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pliu_irq_if irq ();               // Link to interrupt core
  logic [1:0]  cmd_space;           // Memory and I/O enables
  logic        cmd_par_resp;        // Parity error response
  logic        cmd_serr_en;         // System error enable
  logic        stat_sig_serr;       // Sticky, serr signalled
  logic        stat_det_par;        // Sticky, parity error seen
  logic [7:0]  int_line;            // Software scratch for routing
  logic [7:0]  irq_ctrl_status_reg; // Whole written byte, status bits replaced on read
  logic [11:0] misc_control_reg;    // Three bits per user pin
  logic        serr_pulse;          // One-cycle system error
  logic        par_err;             // Any parity error this cycle
  logic [3:0]  user_a;              // Pin sync first stage
  logic [3:0]  user_b;              // Pin sync second stage
  logic [3:0]  alt_val;             // Alternate function levels
  logic [31:0] next_rdata;          // Read mux result
  logic [31:0] wmask;               // Byte enables widened
  logic        wr_cmd;
  logic        wr_line;
  logic        wr_csr;
  logic        wr_ctrl;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wmask   = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
  assign wr_cmd  = i_cfg_wr && !i_cfg_space && (i_cfg_addr == pliu_pkg::OFF_CMD_STAT);
  assign wr_line = i_cfg_wr && !i_cfg_space && (i_cfg_addr == pliu_pkg::OFF_INT_LINE_PIN);
  assign wr_csr  = i_cfg_wr && i_cfg_space && (i_cfg_addr == pliu_pkg::OFF_IRQ_CSR);
  assign wr_ctrl = i_cfg_wr && i_cfg_space && (i_cfg_addr == pliu_pkg::OFF_MISC_CTRL);
  assign par_err = i_addr_par_err | i_data_par_err;

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  // Only the bits this block uses are stored; the rest read zero
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cmd_space    <= 2'b00;
      cmd_par_resp <= 1'b0;
      cmd_serr_en  <= 1'b0;
    end else if (wr_cmd) begin
      if (i_cfg_be[0]) begin
        cmd_space    <= i_cfg_wdata[pliu_pkg::CMD_IO:pliu_pkg::CMD_MEM];
        cmd_par_resp <= i_cfg_wdata[pliu_pkg::CMD_PAR_RESP];
      end
      if (i_cfg_be[1]) begin
        cmd_serr_en <= i_cfg_wdata[pliu_pkg::CMD_SERR_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // Error status, write one to clear
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle so no error is lost
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stat_sig_serr <= 1'b0;
      stat_det_par  <= 1'b0;
    end else begin
      if (serr_pulse) begin
        stat_sig_serr <= 1'b1;
      end else if (wr_cmd && wmask[pliu_pkg::STAT_SIG_SERR] && i_cfg_wdata[pliu_pkg::STAT_SIG_SERR]) begin
        stat_sig_serr <= 1'b0;
      end
      if (par_err) begin
        stat_det_par <= 1'b1;
      end else if (wr_cmd && wmask[pliu_pkg::STAT_DET_PAR] && i_cfg_wdata[pliu_pkg::STAT_DET_PAR]) begin
        stat_det_par <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // System error pulse
  // ----------------------------------------------------------------
  // Needs both parity response and serr enable
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      serr_pulse <= 1'b0;
    end else begin
      serr_pulse <= par_err && cmd_par_resp && cmd_serr_en;
    end
  end
  assign o_serr_n_out = 1'b0;          // Open drain, only ever pulls low
  assign o_serr_oe_n  = ~serr_pulse;

  // ----------------------------------------------------------------
  // Interrupt line and interrupt control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      int_line            <= pliu_pkg::INT_LINE_RESET;
      irq_ctrl_status_reg <= pliu_pkg::CSR_RESET;
    end else begin
      if (wr_line && i_cfg_be[0]) begin
        int_line <= i_cfg_wdata[7:0];
      end
      if (wr_csr && i_cfg_be[0]) begin
        irq_ctrl_status_reg <= i_cfg_wdata[7:0];
      end
    end
  end

  // Controls into the core
  assign irq.lint_en    = {irq_ctrl_status_reg[pliu_pkg::CSR_L2_EN], irq_ctrl_status_reg[pliu_pkg::CSR_L1_EN]};
  assign irq.lint_pol   = {irq_ctrl_status_reg[pliu_pkg::CSR_L2_POL], irq_ctrl_status_reg[pliu_pkg::CSR_L1_POL]};
  assign irq.pci_irq_en = irq_ctrl_status_reg[pliu_pkg::CSR_PCI_EN];
  assign irq.sw_irq     = irq_ctrl_status_reg[pliu_pkg::CSR_SW_IRQ];

  // Interrupt core
  pliu_irq_core u_core (
    .i_mclk         (i_mclk),
    .i_rst          (i_rst),
    .i_local_irq_in (i_local_irq_in),
    .bus            (irq.core)
  );

  // Open drain interrupt pin, enable low while pulling
  assign o_inta_n_out = 1'b0;
  assign o_inta_oe_n  = ~irq.inta_active;

  // ----------------------------------------------------------------
  // User I/O control register
  // ----------------------------------------------------------------
  // Reset value selects user function, input direction
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      misc_control_reg <= pliu_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      if (i_cfg_be[0]) begin
        misc_control_reg[7:0] <= i_cfg_wdata[7:0];
      end
      if (i_cfg_be[1]) begin
        misc_control_reg[11:8] <= i_cfg_wdata[11:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // User pins
  // ----------------------------------------------------------------
  // Pin order: wait, lock, select two, select three
  assign alt_val = {i_chip_select_three_n, i_chip_select_two_n, i_lock_out_n, i_wait_out_n};

  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_pin
      // Input synchroniser; unused inputs need a pull outside
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          user_a[p] <= 1'b0;
          user_b[p] <= 1'b0;
        end else begin
          user_a[p] <= i_user_in[p];
          user_b[p] <= user_a[p];
        end
      end
      // Driver: alternate always drives, user follows direction bit
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          o_user_out[p]  <= 1'b0;
          o_user_oe_n[p] <= 1'b1;
        end else if (misc_control_reg[p*3 + pliu_pkg::USER_ALT]) begin
          o_user_out[p]  <= alt_val[p];
          o_user_oe_n[p] <= 1'b0;
        end else begin
          o_user_out[p]  <= misc_control_reg[p*3 + pliu_pkg::USER_DAT];
          o_user_oe_n[p] <= ~misc_control_reg[p*3 + pliu_pkg::USER_DIR];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read zero; input pins show their level
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (!i_cfg_space && i_cfg_addr == pliu_pkg::OFF_CMD_STAT) begin
      next_rdata[pliu_pkg::CMD_IO:pliu_pkg::CMD_MEM] = cmd_space;
      next_rdata[pliu_pkg::CMD_PAR_RESP]  = cmd_par_resp;
      next_rdata[pliu_pkg::CMD_SERR_EN]   = cmd_serr_en;
      next_rdata[pliu_pkg::STAT_SIG_SERR] = stat_sig_serr;
      next_rdata[pliu_pkg::STAT_DET_PAR]  = stat_det_par;
    end else if (!i_cfg_space && i_cfg_addr == pliu_pkg::OFF_INT_LINE_PIN) begin
      next_rdata[15:0] = {pliu_pkg::INT_PIN_VAL, int_line};
    end else if (i_cfg_space && i_cfg_addr == pliu_pkg::OFF_IRQ_CSR) begin
      next_rdata[7:0] = irq_ctrl_status_reg;
      next_rdata[pliu_pkg::CSR_L1_STAT] = irq.lint_stat[0];
      next_rdata[pliu_pkg::CSR_L2_STAT] = irq.lint_stat[1];
    end else if (i_cfg_space && i_cfg_addr == pliu_pkg::OFF_MISC_CTRL) begin
      next_rdata[11:0] = misc_control_reg;
      for (int k = 0; k < 4; k++) begin
        if (!misc_control_reg[k*3 + pliu_pkg::USER_DIR]) begin
          next_rdata[k*3 + pliu_pkg::USER_DAT] = user_b[k];
        end
      end
    end
  end

  // Answer one cycle after the read strobe
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_cfg_rdata <= 32'h0000_0000;
      o_cfg_ack   <= 1'b0;
    end else begin
      o_cfg_ack <= i_cfg_rd | i_cfg_wr;
      if (i_cfg_rd) begin
        o_cfg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_serr_fire;
    @(posedge i_mclk) disable iff (i_rst)
      (par_err && cmd_par_resp && cmd_serr_en) |=> !o_serr_oe_n ##1 (o_serr_oe_n || $past(par_err));
  endproperty
  a_serr_fire: assert property (p_serr_fire) else $error("system error pulse missing or stretched");

  property p_serr_gate;
    @(posedge i_mclk) disable iff (i_rst)
      (!cmd_serr_en || !cmd_par_resp) |=> o_serr_oe_n;
  endproperty
  a_serr_gate: assert property (p_serr_gate) else $error("system error driven while disabled");

  property p_alt_wait;
    @(posedge i_mclk) disable iff (i_rst)
      misc_control_reg[pliu_pkg::USER_ALT] |=> (!o_user_oe_n[0] && o_user_out[0] == $past(i_wait_out_n));
  endproperty
  a_alt_wait: assert property (p_alt_wait) else $error("pin 0 does not carry wait output");

  property p_dir_in;
    @(posedge i_mclk) disable iff (i_rst)
      (!misc_control_reg[3 + pliu_pkg::USER_ALT] && !misc_control_reg[3 + pliu_pkg::USER_DIR]) |=> o_user_oe_n[1];
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("pin 1 driven while set as input");

  property p_reset_fn;
    @(posedge i_mclk) disable iff (i_rst)
      $fell(i_rst) |-> (misc_control_reg == pliu_pkg::CTRL_RESET);
  endproperty
  a_reset_fn: assert property (p_reset_fn) else $error("pin function not user after reset");

  property p_reset_dir;
    @(posedge i_mclk) disable iff (i_rst)
      $fell(i_rst) |-> (o_user_oe_n == 4'hF) [*2];
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("user pin driven after reset");

endmodule : pliu_top
`default_nettype wire

// ---- bench/pliu_partner.sv ----
// Purpose: Far side of the block: interrupt sources and board wiring of user pins.
// Assumes: Source levels are requested by the bench just after a clock edge.
// Notes:   Undriven user pins float up to a known level through a pull-up.
`timescale 1ns/1ps
`default_nettype none
module pliu_partner (
  // Requested source levels, index 0 is input 1
  input  wire logic [1:0] i_irq_level,
  // User pin drive from the block
  input  wire logic [3:0] i_user_out,
  input  wire logic [3:0] i_user_oe_n,
  // Pin levels seen by the block
  output logic      [1:0] o_local_irq_in,
  output logic      [3:0] o_user_in
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Sources are plain levels, held until the bench changes them
  assign o_local_irq_in = i_irq_level;
  // Pull-up on released pins, never a stale value
  assign o_user_in = (i_user_out & ~i_user_oe_n) | i_user_oe_n;
endmodule : pliu_partner
`default_nettype wire

// ---- bench/pci_local_interrupt_user_io_tb.sv ----
// Purpose: Self-checking bench for the interrupt, system error and user pin block.
// Assumes: Inputs change 1 ns after the rising edge; reset held 20 cycles.
// Notes:   Expected values come from a small integer model in this file.
`timescale 1ns/1ps
`default_nettype none
module pci_local_interrupt_user_io_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        i_mclk = 1'b0;      // 100 MHz clock
  logic        i_rst  = 1'b1;      // Synchronous reset
  logic        wr = 0, rd = 0, sp = 0;
  logic [7:0]  addr  = '0;
  logic [31:0] wdata = '0, rdata;
  logic        ack, inta_out, inta_oe_n, serr_out, serr_oe_n;
  logic        addr_err = 0, data_err = 0;
  logic [3:0]  alt_src = 4'hF;     // Wait, lock, select two, select three
  logic [1:0]  irq_level = 2'b11;  // Both sources idle high
  logic [1:0]  local_irq;
  logic [3:0]  user_in, user_out, user_oe_n;
  logic [31:0] seed = 32'hC04F_B1B1;
  int          fail_count = 0, checks_done = 0;
  int          p, pol, en, lvl, act, v, e, x;

  always #5 i_mclk = ~i_mclk;

  pliu_partner far (.i_irq_level(irq_level), .i_user_out(user_out), .i_user_oe_n(user_oe_n),
                    .o_local_irq_in(local_irq), .o_user_in(user_in));
  pliu_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_space(sp),
    .i_cfg_addr(addr), .i_cfg_be(4'hF), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
    .i_local_irq_in(local_irq), .o_inta_n_out(inta_out), .o_inta_oe_n(inta_oe_n),
    .i_addr_par_err(addr_err), .i_data_par_err(data_err), .o_serr_n_out(serr_out),
    .o_serr_oe_n(serr_oe_n), .i_wait_out_n(alt_src[0]), .i_lock_out_n(alt_src[1]),
    .i_chip_select_two_n(alt_src[2]), .i_chip_select_three_n(alt_src[3]),
    .i_user_in(user_in), .o_user_out(user_out), .o_user_oe_n(user_oe_n));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Galois shift register, fixed seed for repeatable runs
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
  endfunction : lfsr

  // Single comparison point, four-state exact
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One register access; returns in the cycle the ack stands
  task automatic access(input bit w, input bit s, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk) #1;
    wr = w; rd = !w; sp = s; addr = a; wdata = d;
    @(posedge i_mclk) #1;
    wr = 0; rd = 0;
    check("ack", ack, 1);
  endtask : access

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk) #1;
  endtask : step

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200_000;
    fail_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(20);
    i_rst = 0;
    check("inta_rst", inta_oe_n, 1);
    check("inta_val", inta_out, 0);
    check("serr_val", serr_out, 0);
    check("user_oe_rst", user_oe_n, 4'hF);
    // Let the pin synchronisers flush; released inputs read their pull-up
    step(2);
    access(0, 1, 8'h50, 0); check("ctrl_rst", rdata, 32'h0000_0924);
    access(0, 1, 8'h4C, 0); check("csr_rst", rdata, 0);
    // Software source raises and drops the level with exact latency
    access(1, 1, 8'h4C, 32'h80); step(1); check("inta_sw", inta_oe_n, 0);
    access(1, 1, 8'h4C, 32'h00); step(1); check("inta_sw_off", inta_oe_n, 1);
    // Every input, polarity, enable, level and global enable
    for (int k = 0; k < 32; k++) begin
      p = k & 1; pol = (k >> 1) & 1; en = (k >> 2) & 1; lvl = (k >> 3) & 1;
      v = (k >> 4) << 6 | en << (3 * p) | pol << (3 * p + 1);
      irq_level = 2'b11;
      irq_level[p] = lvl[0];
      act = (lvl == pol);                          // Other input stays inactive low-active
      access(1, 1, 8'h4C, v); step(4);
      check("inta_lvl", inta_oe_n, !(act && en && (k >> 4)));
      access(0, 1, 8'h4C, 0); check("csr_stat", rdata, v | act << (3 * p + 2));
    end
    irq_level = 2'b11;
    // Parity errors against both command gates
    for (int k = 0; k < 8; k++) begin
      access(1, 0, 8'h04, (k & 1) << 6 | ((k >> 1) & 1) << 8);
      @(posedge i_mclk) #1; addr_err = k[2]; data_err = !k[2];
      @(posedge i_mclk) #1; addr_err = 0; data_err = 0;
      check("serr_pulse", serr_oe_n, !((k & 3) == 3));
      step(1); check("serr_end", serr_oe_n, 1);
    end
    // Sticky status bits, then write one to clear with all command bits set
    access(0, 0, 8'h04, 0); check("stat_set", rdata, 32'hC000_0140);
    access(1, 0, 8'h04, 32'hC000_0143);
    access(0, 0, 8'h04, 0); check("stat_clr", rdata, 32'h0000_0143);
    // Random pin configurations, alternate sources random as well
    for (int k = 0; k < 12; k++) begin
      seed = lfsr(seed); v = seed[11:0]; alt_src = seed[19:16];
      // Two edges so the synchronised pin level is settled before the read
      access(1, 1, 8'h50, v); step(2);
      x = v;
      for (int q = 0; q < 4; q++) begin
        e = (v >> (3 * q)) & 7;
        check("user_oe", user_oe_n[q], !(e & 3));
        if (e & 1) check("alt_out", user_out[q], alt_src[q]);
        else if (e & 2) check("user_out", user_out[q], (e >> 2) & 1);
        // Input pins read their level: alternate value, else the pull-up
        if (!(e & 2)) x = (x & ~(1 << (3 * q + 2))) | (((e & 1) ? int'(alt_src[q]) : 1) << (3 * q + 2));
      end
      access(0, 1, 8'h50, 0); check("ctrl_rd", rdata, x);
    end
    // Reset in mid-run, with pins configured, must restore user inputs
    i_rst = 1;
    step(3);
    i_rst = 0;
    step(2);
    check("user_oe_rst2", user_oe_n, 4'hF);
    access(0, 1, 8'h50, 0); check("ctrl_rst2", rdata, 32'h0000_0924);
    close_out();
  end
endmodule : pci_local_interrupt_user_io_tb
`default_nettype wire
